// ---- hdl/acbp_pkg.sv ----
/*
 Package for the asynchronous control bus port: widths, reset values and the
 handshake states of both ends. Assumes both ends include it before use.
*/
package acbp_pkg;
    localparam int ACBP_DATA_W = 8;
    localparam int ACBP_ADDR_W = 9;
    localparam int ACBP_NUM_IRQ = 2;
    localparam int ACBP_IRQ_MGMT = 0;
    localparam int ACBP_IRQ_DATA = 1;
    localparam logic [7:0] ACBP_DATA_RST = 8'h00;
    localparam logic [8:0] ACBP_ADDR_RST = 9'h000;
    localparam logic [1:0] ACBP_SYNC_RST = 2'h3;
    localparam logic [1:0] ACBP_SYNC_RST_LO = 2'h0;

    typedef enum logic [3:0] {
        ACBP_DEV_IDLE = 4'h1,
        ACBP_DEV_EXEC = 4'h2,
        ACBP_DEV_ACK = 4'h4,
        ACBP_DEV_DONE = 4'h8
    } acbp_dev_state_t;

    typedef enum logic [2:0] {
        ACBP_HST_IDLE = 3'h1,
        ACBP_HST_WAIT = 3'h2,
        ACBP_HST_REL = 3'h4
    } acbp_hst_state_t;

    function automatic logic acbp_odd_par(input logic [7:0] d);
        return ~(^d);
    endfunction
endpackage

// ---- hdl/acbp_if.sv ----
/*
 Interface joining the host end and the device end of the control bus.
 Resolves the shared data bus and the open-drain lines from the enables;
 released open-drain lines read high as if pulled up.
*/
`timescale 1ns/1ps
interface acbp_if;
    logic strobe_n;
    logic rd_wr;
    logic [8:0] ctl_reg_select;
    logic [7:0] hst_data_o;
    logic hst_par_o;
    logic hst_data_oe;
    logic [7:0] dev_data_o;
    logic dev_par_o;
    logic dev_data_oe;
    logic ack_oe;
    logic [1:0] irq_oe;
    logic [7:0] ctl_bus_data;
    logic ctl_bus_parity;
    logic ack_n;
    logic [1:0] event_irq_n;

    assign ctl_bus_data = dev_data_oe ? dev_data_o : (hst_data_oe ? hst_data_o : 8'hff);
    assign ctl_bus_parity = dev_data_oe ? dev_par_o : (hst_data_oe ? hst_par_o : 1'b1);
    assign ack_n = ~ack_oe;
    assign event_irq_n = ~irq_oe;

    modport host (
        output strobe_n, rd_wr, ctl_reg_select, hst_data_o, hst_par_o, hst_data_oe,
        input ctl_bus_data, ctl_bus_parity, ack_n, event_irq_n
    );
    modport device (
        input strobe_n, rd_wr, ctl_reg_select, ctl_bus_data, ctl_bus_parity,
        output dev_data_o, dev_par_o, dev_data_oe, ack_oe, irq_oe
    );
endinterface

// ---- hdl/acbp_device.sv ----
/*
 Device end of the asynchronous control bus port.
 Assumes the host keeps strobe, direction, address and write data stable
 until acknowledge, and that the register core answers on the same clock.
*/
`timescale 1ns/1ps
module acbp_device
    import acbp_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Control bus
    acbp_if.device bus,
    // Register core side
    output logic reg_wr_stb,
    output logic reg_rd_stb,
    output logic [acbp_pkg::ACBP_ADDR_W-1:0] reg_addr,
    output logic [acbp_pkg::ACBP_DATA_W-1:0] reg_wdata,
    output logic reg_wpar_err,
    input wire logic [acbp_pkg::ACBP_DATA_W-1:0] reg_rdata,
    // Enabled event conditions
    input wire logic [acbp_pkg::ACBP_NUM_IRQ-1:0] event_pending
);
    import acbp_pkg::*;

    acbp_dev_state_t state_ff, nxt_state;
    logic [1:0] stb_sync_ff;
    logic [1:0] dir_sync_ff;
    logic [ACBP_ADDR_W-1:0] addr_sync0_ff, addr_sync1_ff;
    logic [ACBP_DATA_W-1:0] wd_sync0_ff, wd_sync1_ff;
    logic [1:0] wp_sync_ff;
    logic [ACBP_DATA_W-1:0] rdata_ff;
    logic rd_oe_ff;
    logic ack_ff;
    logic [ACBP_NUM_IRQ-1:0] irq_ff;
    logic strobe_act;
    logic rpar_ff;
    genvar gi;

    // Both register strobes come from the same state, so decode it once
    function automatic logic acbp_is_exec(input acbp_dev_state_t s);
        return s == ACBP_DEV_EXEC;
    endfunction

    // Every host line is treated as asynchronous; two stages each
    // Strobe: single bit, plain two-flop synchroniser
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stb_sync_ff <= ACBP_SYNC_RST;
        end else begin
            stb_sync_ff <= {stb_sync_ff[0], bus.strobe_n};
        end
    end

    // Direction: changes on the same host edge as the strobe and passes the same two stages
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dir_sync_ff <= ACBP_SYNC_RST;
        end else begin
            dir_sync_ff <= {dir_sync_ff[0], bus.rd_wr};
        end
    end

    // Write parity follows the data it covers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wp_sync_ff <= ACBP_SYNC_RST;
        end else begin
            wp_sync_ff <= {wp_sync_ff[0], bus.ctl_bus_parity};
        end
    end

    // Address: safe as a word only because the host holds it until ack
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_sync0_ff <= ACBP_ADDR_RST;
            addr_sync1_ff <= ACBP_ADDR_RST;
        end else begin
            addr_sync0_ff <= bus.ctl_reg_select;
            addr_sync1_ff <= addr_sync0_ff;
        end
    end

    // Write data: same reasoning as the address
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wd_sync0_ff <= ACBP_DATA_RST;
            wd_sync1_ff <= ACBP_DATA_RST;
        end else begin
            wd_sync0_ff <= bus.ctl_bus_data;
            wd_sync1_ff <= wd_sync0_ff;
        end
    end

    // Multi-bit address and data are safe because the host holds them until ack
    assign strobe_act = ~stb_sync_ff[1];

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ACBP_DEV_IDLE: begin
                if (strobe_act) begin
                    nxt_state = ACBP_DEV_EXEC;
                end
            end
            ACBP_DEV_EXEC: begin
                nxt_state = ACBP_DEV_ACK;
            end
            ACBP_DEV_ACK: begin
                if (!strobe_act) begin
                    nxt_state = ACBP_DEV_DONE;
                end
            end
            ACBP_DEV_DONE: begin
                nxt_state = ACBP_DEV_IDLE;
            end
            default: begin
                nxt_state = ACBP_DEV_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ACBP_DEV_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // One-cycle strobe to the register core; address is decoded there
    assign reg_wr_stb = acbp_is_exec(state_ff) && !dir_sync_ff[1];
    assign reg_rd_stb = acbp_is_exec(state_ff) && dir_sync_ff[1];
    assign reg_addr = addr_sync1_ff;
    assign reg_wdata = wd_sync1_ff;
    assign reg_wpar_err = reg_wr_stb && (wp_sync_ff[1] != acbp_odd_par(wd_sync1_ff));

    // Read data captured in the same cycle the read is carried out
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= ACBP_DATA_RST;
        end else if (reg_rd_stb) begin
            rdata_ff <= reg_rdata;
        end
    end

    // Parity registered with the data so both leave the device together
    // Reset value is the odd parity of the all-zero reset data
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rpar_ff <= 1'b1;
        end else if (reg_rd_stb) begin
            rpar_ff <= acbp_odd_par(reg_rdata);
        end
    end

    // Ack only after the access has happened, held until strobe goes away
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (nxt_state == ACBP_DEV_ACK);
        end
    end

    // Read data enable rises with ack, so the host never samples an undriven bus
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_oe_ff <= 1'b0;
        end else begin
            rd_oe_ff <= (nxt_state == ACBP_DEV_ACK) && dir_sync_ff[1];
        end
    end

    // One flop per interrupt line; the lines are independent
    generate
        for (gi = 0; gi < ACBP_NUM_IRQ; gi++) begin : g_irq
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    irq_ff[gi] <= 1'b0;
                end else begin
                    irq_ff[gi] <= event_pending[gi];
                end
            end
        end
    endgenerate

    // Open drain: only an enable leaves this end, never a driven high
    assign bus.ack_oe = ack_ff;
    assign bus.irq_oe = irq_ff;
    // Bus driven only while a read is acknowledged
    assign bus.dev_data_oe = rd_oe_ff;
    assign bus.dev_data_o = rdata_ff;
    assign bus.dev_par_o = rpar_ff;
endmodule

// ---- hdl/acbp_host.sv ----
/*
 Host end of the asynchronous control bus port.
 Takes one request at a time from user logic; assumes the device
 acknowledges and later releases acknowledge after the strobe goes high.
*/
`timescale 1ns/1ps
module acbp_host
    import acbp_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Control bus
    acbp_if.host bus,
    // User request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_read,
    input wire logic [acbp_pkg::ACBP_ADDR_W-1:0] req_addr,
    input wire logic [acbp_pkg::ACBP_DATA_W-1:0] req_wdata,
    // User answer
    output logic rsp_valid,
    output logic [acbp_pkg::ACBP_DATA_W-1:0] rsp_rdata,
    output logic rsp_par_err,
    output logic [acbp_pkg::ACBP_NUM_IRQ-1:0] irq_level
);
    import acbp_pkg::*;

    acbp_hst_state_t state_ff, nxt_state;
    logic [1:0] ack_sync_ff;
    logic [1:0] irq_s0_ff, irq_s1_ff;
    logic stb_n_ff, dir_ff, oe_ff;
    logic [ACBP_ADDR_W-1:0] addr_ff;
    logic [ACBP_DATA_W-1:0] wd_ff, rd_ff;
    logic rsp_ff, perr_ff;
    logic ack_seen;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_sync_ff <= ACBP_SYNC_RST;
            irq_s0_ff <= ACBP_SYNC_RST;
            irq_s1_ff <= ACBP_SYNC_RST;
        end else begin
            ack_sync_ff <= {ack_sync_ff[0], bus.ack_n};
            irq_s0_ff <= bus.event_irq_n;
            irq_s1_ff <= irq_s0_ff;
        end
    end
    assign ack_seen = ~ack_sync_ff[1];

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ACBP_HST_IDLE: begin
                if (req_valid && !ack_seen) begin
                    nxt_state = ACBP_HST_WAIT;
                end
            end
            ACBP_HST_WAIT: begin
                if (ack_seen) begin
                    nxt_state = ACBP_HST_REL;
                end
            end
            ACBP_HST_REL: begin
                if (!ack_seen) begin
                    nxt_state = ACBP_HST_IDLE;
                end
            end
            default: begin
                nxt_state = ACBP_HST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ACBP_HST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign req_ready = (state_ff == ACBP_HST_IDLE) && !ack_seen;

    // Drive lines stable for the whole access; strobe falls on the edge that loads the others and rises on the edge that drops the data enable
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stb_n_ff <= 1'b1;
            dir_ff <= 1'b1;
            oe_ff <= 1'b0;
            addr_ff <= ACBP_ADDR_RST;
            wd_ff <= ACBP_DATA_RST;
        end else if (req_valid && req_ready) begin
            stb_n_ff <= 1'b0;
            dir_ff <= req_read;
            oe_ff <= !req_read;
            addr_ff <= req_addr;
            wd_ff <= req_wdata;
        end else if (state_ff == ACBP_HST_WAIT && ack_seen) begin
            stb_n_ff <= 1'b1;
            oe_ff <= 1'b0;
        end
    end

    // Read data sampled when ack is seen; device holds it while ack stays low
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_ff <= ACBP_DATA_RST;
            rsp_ff <= 1'b0;
            perr_ff <= 1'b0;
        end else begin
            rsp_ff <= (state_ff == ACBP_HST_WAIT) && ack_seen;
            if ((state_ff == ACBP_HST_WAIT) && ack_seen && dir_ff) begin
                rd_ff <= bus.ctl_bus_data;
                perr_ff <= bus.ctl_bus_parity != acbp_odd_par(bus.ctl_bus_data);
            end else if ((state_ff == ACBP_HST_WAIT) && ack_seen) begin
                perr_ff <= 1'b0;
            end
        end
    end

    assign bus.strobe_n = stb_n_ff;
    assign bus.rd_wr = dir_ff;
    assign bus.ctl_reg_select = addr_ff;
    assign bus.hst_data_o = wd_ff;
    assign bus.hst_par_o = acbp_odd_par(wd_ff);
    assign bus.hst_data_oe = oe_ff;
    assign rsp_valid = rsp_ff;
    assign rsp_rdata = rd_ff;
    assign rsp_par_err = perr_ff;
    assign irq_level = ~irq_s1_ff;
endmodule

// ---- verification/acbp_sva.sv ----
/*
 Checker for the control bus joining host and device ends.
 Assumes one clock and the interface signals wired in by name.
*/
`timescale 1ns/1ps
module acbp_sva (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Bus
    input wire logic strobe_n,
    input wire logic rd_wr,
    input wire logic [8:0] ctl_reg_select,
    input wire logic hst_data_oe,
    input wire logic dev_data_oe,
    input wire logic ack_oe,
    input wire logic [1:0] irq_oe,
    input wire logic [7:0] ctl_bus_data,
    input wire logic ctl_bus_parity,
    // Device events
    input wire logic [1:0] event_pending
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_no_fight; !(dev_data_oe && hst_data_oe); endproperty
    a_no_fight: assert property (p_no_fight) else $error("data bus driven by both ends");
    property p_dev_rd; dev_data_oe && !strobe_n |-> rd_wr; endproperty
    a_dev_rd: assert property (p_dev_rd) else $error("device drives data on a write");
    property p_hst_wr; hst_data_oe |-> !rd_wr && !strobe_n; endproperty
    a_hst_wr: assert property (p_hst_wr) else $error("host drives data outside a write");
    property p_par; dev_data_oe || hst_data_oe |-> ^{ctl_bus_parity, ctl_bus_data} == 1'b1; endproperty
    a_par: assert property (p_par) else $error("bus parity not odd");
    property p_ack_rise; $rose(ack_oe) |-> !strobe_n && $past(strobe_n, 3) == 1'b0; endproperty
    a_ack_rise: assert property (p_ack_rise) else $error("acknowledge before synchronised strobe");
    property p_ack_soon; $fell(strobe_n) |-> ##[3:8] ack_oe; endproperty
    a_ack_soon: assert property (p_ack_soon) else $error("acknowledge missing");
    property p_ack_hold; ack_oe && !strobe_n |=> ack_oe; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("acknowledge dropped early");
    property p_ack_rel; $rose(strobe_n) |-> ##[1:6] !ack_oe; endproperty
    a_ack_rel: assert property (p_ack_rel) else $error("acknowledge not released");
    property p_hold;
        !strobe_n && $past(strobe_n) == 1'b0 |-> $stable(ctl_reg_select) && $stable(rd_wr)
            && (!hst_data_oe || $stable(ctl_bus_data));
    endproperty
    a_hold: assert property (p_hold) else $error("request changed before acknowledge");
    property p_irq; $past(reset_n) |-> irq_oe == $past(event_pending); endproperty
    a_irq: assert property (p_irq) else $error("interrupt does not follow events");
endmodule

// ---- verification/tb_top.sv ----
/*
 Testbench: host and device ends joined by the interface, with a small
 register core. Assumes package and design files are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
    import acbp_pkg::*;
    typedef struct packed {logic rd; logic [7:0] data;} acbp_exp_t;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_read = 1'b0;
    logic [8:0] req_addr = 9'h000;
    logic [7:0] req_wdata = 8'h00;
    logic [1:0] event_pending = 2'h0;
    logic req_ready, rsp_valid, rsp_par_err, reg_wr_stb, reg_rd_stb, reg_wpar_err;
    logic [7:0] rsp_rdata, reg_wdata, reg_rdata;
    logic [8:0] reg_addr;
    logic [1:0] irq_level;
    logic [7:0] core_mem [512];
    logic [7:0] exp_mem [512];
    acbp_exp_t rsp_q[$];
    logic [16:0] wr_q[$];
    acbp_exp_t e;
    logic [16:0] w;
    int bad_count = 0;
    int checked = 0;
    logic [31:0] rng = 32'h7b9c;
    acbp_if bus_if ();
    acbp_host acbp_host_inst (.sys_clk(sys_clk), .reset_n(reset_n), .bus(bus_if), .req_valid(req_valid),
        .req_ready(req_ready), .req_read(req_read), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_par_err(rsp_par_err), .irq_level(irq_level));
    acbp_device acbp_device_inst (.sys_clk(sys_clk), .reset_n(reset_n), .bus(bus_if), .reg_wr_stb(reg_wr_stb),
        .reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wpar_err(reg_wpar_err),
        .reg_rdata(reg_rdata), .event_pending(event_pending));
    acbp_sva acbp_sva_inst (.sys_clk(sys_clk), .reset_n(reset_n), .strobe_n(bus_if.strobe_n),
        .rd_wr(bus_if.rd_wr), .ctl_reg_select(bus_if.ctl_reg_select), .hst_data_oe(bus_if.hst_data_oe),
        .dev_data_oe(bus_if.dev_data_oe), .ack_oe(bus_if.ack_oe), .irq_oe(bus_if.irq_oe),
        .ctl_bus_data(bus_if.ctl_bus_data), .ctl_bus_parity(bus_if.ctl_bus_parity),
        .event_pending(event_pending));
    // Register core: combinational read as the device end expects
    assign reg_rdata = core_mem[reg_addr];
    always @(posedge sys_clk) begin
        if (reg_wr_stb === 1'b1) begin
            core_mem[reg_addr] <= reg_wdata;
        end
    end
    task automatic cmp_val(input string what, input logic [8:0] exp, input logic [8:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Holds the request until the edge that takes it; no back to back
    task automatic access(input logic rd, input logic [8:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        #1;
        req_valid = 1'b1;
        req_read = rd;
        req_addr = a;
        req_wdata = d;
        while (req_ready !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 60) begin
                bad_count++;
                summarize();
            end
        end
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
        rsp_q.push_back({rd, exp_mem[a]});
        if (!rd) begin
            exp_mem[a] = d;
            wr_q.push_back({a, d});
        end
    endtask
    always @(posedge sys_clk) begin
        if (reg_wr_stb === 1'b1) begin
            w = (wr_q.size() > 0) ? wr_q.pop_front() : 17'h1ffff;
            cmp_val("reg_addr", w[16:8], reg_addr);
            cmp_val("reg_wdata", {1'b0, w[7:0]}, {1'b0, reg_wdata});
            cmp_val("reg_wpar_err", 9'h000, {8'h00, reg_wpar_err});
        end
        if (rsp_valid === 1'b1) begin
            cmp_val("rsp_count", 9'h001, {8'h00, rsp_q.size() > 0});
            e = rsp_q.pop_front();
            if (e.rd) begin
                cmp_val("rsp_rdata", {1'b0, e.data}, {1'b0, rsp_rdata});
            end
            cmp_val("rsp_par_err", 9'h000, {8'h00, rsp_par_err});
        end
    end
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        for (int i = 0; i < 512; i++) begin
            core_mem[i] = i[7:0] ^ 8'h5a;
            exp_mem[i] = i[7:0] ^ 8'h5a;
        end
        repeat (8) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int i = 0; i < 40; i++) begin
            repeat (6) @(posedge sys_clk);
            #1;
            cmp_val("irq_level", {7'h00, event_pending}, {7'h00, irq_level});
            rng = xs(rng);
            event_pending = rng[26:25];
            req_addr = (i == 0) ? 9'h000 : ((i == 1) ? 9'h1ff : rng[8:0]);
            access(1'b0, req_addr, rng[16:9]);
            access(1'b1, req_addr, 8'h00);
            access(1'b1, rng[24:16], 8'h00);
        end
        for (int n = 0; n < 100 && rsp_q.size() != 0; n++) begin
            @(posedge sys_clk);
        end
        #1;
        cmp_val("rsp_left", 9'h000, rsp_q.size() > 0 ? 9'h001 : 9'h000);
        summarize();
    end
endmodule
